// file: shared/lpm_defs.svh
// Offsets, field positions, reset values and timing counts of the power-mode controller
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

`define LPM_ADDR_W 8
`define LPM_DATA_W 32
`define LPM_NPCLK 8
`define LPM_NWAKE 6
`define LPM_NTAMPER 2
`define LPM_CNT_W 13

`define LPM_OFS_CTRL 8'h00
`define LPM_OFS_WAKE 8'h04
`define LPM_OFS_DEBUG 8'h08
`define LPM_OFS_STATUS 8'h0C
`define LPM_OFS_CLKLIM 8'h10
`define LPM_OFS_PCLK 8'h14

`define LPM_CTRL_DEEP 0
`define LPM_CTRL_STBY 1
`define LPM_CTRL_LPREG 2
`define LPM_CTRL_UDRV 3
`define LPM_CTRL_SCALE_LO 4
`define LPM_CTRL_SCALE_HI 5
`define LPM_CTRL_ODRV 6
`define LPM_CTRL_RTS 7
`define LPM_CTRL_BKP_UNLOCK 8
`define LPM_WAKE_EN_LO 0
`define LPM_WAKE_POL_LO 8
`define LPM_ST_MODE_LO 0
`define LPM_ST_BATT 4
`define LPM_ST_TAMPER 5
`define LPM_ST_HSI 6

`define LPM_SCALE_RST 2'h1
`define LPM_PCLK_RST 8'hFF

`define LPM_SCALE1_MHZ 16'h00B4
`define LPM_SCALE1_OD_MHZ 16'h00D8
`define LPM_SCALE2_MHZ 16'h00A8
`define LPM_SCALE2_OD_MHZ 16'h00B4
`define LPM_SCALE3_MHZ 16'h0090

`define LPM_CLK_PERIOD_NS 50
`define LPM_STOP_WAKE_MIN_NS 15000
`define LPM_STOP_WAKE_MAX_NS 120000
`define LPM_STBY_WAKE_NS 313000
`define LPM_STOP_WAKE_MIN_CYC ((`LPM_STOP_WAKE_MIN_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS)
`define LPM_STOP_WAKE_MAX_CYC (`LPM_STOP_WAKE_MAX_NS / `LPM_CLK_PERIOD_NS)
`define LPM_STBY_WAKE_CYC (`LPM_STBY_WAKE_NS / `LPM_CLK_PERIOD_NS)

`endif

// file: shared/lpm_pkg.sv
// Types of the power-mode controller
`include "lpm_defs.svh"
package lpm_pkg;
  typedef enum logic [2:0] {
    LPM_RUN = 3'h0,
    LPM_SLEEP = 3'h1,
    LPM_STOP = 3'h2,
    LPM_STOP_WAKE = 3'h3,
    LPM_STANDBY = 3'h4,
    LPM_STBY_WAKE = 3'h5,
    LPM_RST_REQ = 3'h6
  } lpm_mode_t;

  typedef struct packed {
    lpm_mode_t mode;
    logic [`LPM_CNT_W-1:0] cnt;
    logic deep;
    logic stby_sel;
    logic lp_reg_sel;
    logic udrv_sel;
    logic [1:0] scale;
    logic odrv;
    logic rts;
    logic bkp_unlock;
    logic [`LPM_NWAKE-1:0] wk_en;
    logic [`LPM_NWAKE-1:0] wk_pol;
    logic [2:0] dbg;
    logic [`LPM_NPCLK-1:0] pclk_sleep;
    logic tamper_flag;
    logic hsi_flag;
    logic [`LPM_DATA_W-1:0] rdata;
    logic main_reg;
    logic lp_reg;
    logic udrv_on;
    logic cpu_clk;
    logic bus_clk;
    logic free_running_core_clock;
    logic hs_clk;
    logic io_hiz;
    logic ulp_bor;
    logic core_retain;
    logic bkp_wr;
    logic erase;
    logic on_bat;
    logic rst_req;
    logic [`LPM_NPCLK-1:0] pclk;
  } lpm_state_t;
endpackage

// file: src/lpm_ctrl.sv
// Power-mode controller: run, sleep, stop and standby sequencing with backup-domain control
//
// Behaviour
// (RULE1) Core runs on main regulator in run and sleep; stop picks main or low-power.
// (RULE2) Standby turns every core regulator off; core state is lost.
// (RULE3) Backup-domain writes blocked after any reset until software unlocks them.
// (RULE4) Three voltage scales; clock limits 180/216, 168/180, 144 MHz read back.
// (RULE5) Sleep halts the CPU clock; peripheral clocks follow a software mask.
// (RULE6) Wait instruction enters sleep; with return-to-sleep, the lowest handler exit does.
// (RULE7) Stop halts all fast clocks, keeps SRAM and peripherals; slow oscillators may run.
// (RULE8) Any external event line leaves stop.
// (RULE9) Stop to run takes between 15 and 120 microseconds.
// (RULE10) After stop the system clock comes from the internal fast oscillator.
// (RULE11) Under-drive in stop keeps the core domain in low leakage, contents kept.
// (RULE12) Standby keeps only backup registers and backup SRAM.
// (RULE13) Standby puts I/Os in high impedance and keeps the ultra-low brown-out reset on.
// (RULE14) Six standby wakeup pins, each with its own active polarity.
// (RULE15) Standby wakeup requests a full system reset after about 313 microseconds.
// (RULE16) Two tamper inputs on battery; intrusion erases backup registers.
// (RULE17) Backup domain moves to battery while main supply is low, and back.
// (RULE18) Cleared option bit makes stop or standby entry request a reset instead.
// (RULE19) Debug bits keep bus and core clocks, and standby regulator, running.
// (RULE20) Deep-sleep selection picks stop or standby; otherwise plain sleep.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defs.svh"

module lpm_ctrl #(
  parameter int STBY_WAKE_CYCLES = `LPM_STBY_WAKE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [`LPM_ADDR_W-1:0] i_addr,
  input wire logic [`LPM_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_wfi,
  input wire logic i_wfe,
  input wire logic i_isr_exit_lowest,
  input wire logic i_irq_pending,
  input wire logic i_external_event_lines,
  input wire logic [`LPM_NWAKE-1:0] i_wake_pin,
  input wire logic [`LPM_NTAMPER-1:0] i_tamper,
  input wire logic i_main_supply_ok,
  input wire logic i_opt_stop_allow,
  input wire logic i_opt_stby_allow,
  output logic [`LPM_DATA_W-1:0] o_rdata,
  output lpm_pkg::lpm_mode_t o_mode,
  output logic o_main_reg_on,
  output logic o_lp_reg_on,
  output logic o_under_drive,
  output logic o_cpu_clk_en,
  output logic o_bus_clk_en,
  output logic o_free_running_core_clock_en,
  output logic o_hs_clk_en,
  output logic o_sysclk_internal_fast_oscillator,
  output logic o_io_hiz,
  output logic o_ulp_bor_on,
  output logic o_core_retain,
  output logic o_backup_wr_en,
  output logic o_backup_erase,
  output logic o_backup_on_battery,
  output logic o_sys_reset_req,
  output logic [`LPM_NPCLK-1:0] o_periph_clk_en
);
  import lpm_pkg::*;

  localparam logic [`LPM_CNT_W-1:0] STOP_FAST_LOAD = `LPM_CNT_W'(`LPM_STOP_WAKE_MIN_CYC - 1);
  localparam logic [`LPM_CNT_W-1:0] STOP_SLOW_LOAD = `LPM_CNT_W'(`LPM_STOP_WAKE_MAX_CYC - 1);
  localparam logic [`LPM_CNT_W-1:0] STBY_LOAD = `LPM_CNT_W'(STBY_WAKE_CYCLES - 1);

  lpm_state_t s_reg;
  lpm_state_t s_next;
  logic sleep_req;
  logic stby_wake;
  logic [15:0] clk_limit;
  lpm_mode_t m;

  always_comb begin
    clk_limit = `LPM_SCALE3_MHZ;
    case (s_reg.scale)
      2'h1: clk_limit = s_reg.odrv ? `LPM_SCALE1_OD_MHZ : `LPM_SCALE1_MHZ; // [RULE4]
      2'h2: clk_limit = s_reg.odrv ? `LPM_SCALE2_OD_MHZ : `LPM_SCALE2_MHZ; // [RULE4]
      default: clk_limit = `LPM_SCALE3_MHZ;
    endcase
  end

  // Return-to-sleep replaces the instruction trigger by the handler exit
  assign sleep_req = s_reg.rts ? i_isr_exit_lowest : (i_wfi | i_wfe); // [RULE6]
  // Polarity bit set means the pin wakes when low
  assign stby_wake = |(s_reg.wk_en & (i_wake_pin ^ s_reg.wk_pol)); // [RULE14]

  always_comb begin
    s_next = s_reg;
    s_next.rdata = '0;
    m = s_reg.mode;

    if (i_wr) begin
      case (i_addr)
        `LPM_OFS_CTRL: begin
          s_next.deep = i_wdata[`LPM_CTRL_DEEP];
          s_next.stby_sel = i_wdata[`LPM_CTRL_STBY];
          s_next.lp_reg_sel = i_wdata[`LPM_CTRL_LPREG];
          s_next.udrv_sel = i_wdata[`LPM_CTRL_UDRV];
          s_next.scale = i_wdata[`LPM_CTRL_SCALE_HI:`LPM_CTRL_SCALE_LO];
          s_next.odrv = i_wdata[`LPM_CTRL_ODRV];
          s_next.rts = i_wdata[`LPM_CTRL_RTS];
          s_next.bkp_unlock = i_wdata[`LPM_CTRL_BKP_UNLOCK]; // [RULE3]
        end
        `LPM_OFS_WAKE: begin
          s_next.wk_en = i_wdata[`LPM_WAKE_EN_LO +: `LPM_NWAKE];
          s_next.wk_pol = i_wdata[`LPM_WAKE_POL_LO +: `LPM_NWAKE];
        end
        `LPM_OFS_DEBUG: s_next.dbg = i_wdata[2:0];
        `LPM_OFS_PCLK: s_next.pclk_sleep = i_wdata[`LPM_NPCLK-1:0];
        `LPM_OFS_STATUS: begin
          if (i_wdata[`LPM_ST_TAMPER]) begin
            s_next.tamper_flag = 1'b0;
          end
          if (i_wdata[`LPM_ST_HSI]) begin
            s_next.hsi_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (i_rd) begin
      case (i_addr)
        `LPM_OFS_CTRL: s_next.rdata = {23'h0, s_reg.bkp_unlock, s_reg.rts, s_reg.odrv, s_reg.scale,
                                       s_reg.udrv_sel, s_reg.lp_reg_sel, s_reg.stby_sel, s_reg.deep};
        `LPM_OFS_WAKE: s_next.rdata = {18'h0, s_reg.wk_pol, 2'h0, s_reg.wk_en};
        `LPM_OFS_DEBUG: s_next.rdata = {29'h0, s_reg.dbg};
        `LPM_OFS_STATUS: s_next.rdata = {25'h0, s_reg.hsi_flag, s_reg.tamper_flag, s_reg.on_bat,
                                         1'b0, s_reg.mode};
        `LPM_OFS_CLKLIM: s_next.rdata = {16'h0, clk_limit};
        `LPM_OFS_PCLK: s_next.rdata = {24'h0, s_reg.pclk_sleep};
        default: s_next.rdata = '0;
      endcase
    end

    case (s_reg.mode)
      LPM_RUN: begin
        if (sleep_req) begin
          if (!s_reg.deep) begin
            m = LPM_SLEEP; // [RULE20]
          end else if (s_reg.stby_sel) begin
            m = i_opt_stby_allow ? LPM_STANDBY : LPM_RST_REQ; // [RULE18] [RULE20]
          end else begin
            m = i_opt_stop_allow ? LPM_STOP : LPM_RST_REQ; // [RULE18] [RULE20]
          end
        end
      end
      LPM_SLEEP: begin
        if (i_irq_pending | i_external_event_lines) begin
          m = LPM_RUN;
        end
      end
      LPM_STOP: begin
        if (i_external_event_lines) begin
          m = LPM_STOP_WAKE; // [RULE8]
          // Low-power regulator and under-drive need the long ramp
          s_next.cnt = (s_reg.lp_reg_sel | s_reg.udrv_sel) ? STOP_SLOW_LOAD : STOP_FAST_LOAD; // [RULE9]
        end
      end
      LPM_STOP_WAKE: begin
        if (s_reg.cnt == '0) begin
          m = LPM_RUN; // [RULE9]
          s_next.hsi_flag = 1'b1; // [RULE10]
        end else begin
          s_next.cnt = s_reg.cnt - `LPM_CNT_W'(1);
        end
      end
      LPM_STANDBY: begin
        if (stby_wake) begin
          m = LPM_STBY_WAKE;
          s_next.cnt = STBY_LOAD; // [RULE15]
        end
      end
      LPM_STBY_WAKE: begin
        if (s_reg.cnt == '0) begin
          m = LPM_RST_REQ; // [RULE15]
        end else begin
          s_next.cnt = s_reg.cnt - `LPM_CNT_W'(1);
        end
      end
      LPM_RST_REQ: m = LPM_RST_REQ;
      default: m = LPM_RUN;
    endcase
    s_next.mode = m;

    // Set after the clear so an intrusion in the clearing cycle survives
    if (|i_tamper) begin
      s_next.tamper_flag = 1'b1; // [RULE16]
    end

    s_next.main_reg = (m == LPM_RUN) || (m == LPM_SLEEP) || (m == LPM_STOP_WAKE) || (m == LPM_RST_REQ) ||
                      ((m == LPM_STOP) && !s_reg.lp_reg_sel) ||
                      (((m == LPM_STANDBY) || (m == LPM_STBY_WAKE)) && s_reg.dbg[2]); // [RULE1] [RULE2] [RULE19]
    s_next.lp_reg = (m == LPM_STOP) && s_reg.lp_reg_sel; // [RULE1]
    s_next.udrv_on = (m == LPM_STOP) && s_reg.udrv_sel; // [RULE11]
    s_next.cpu_clk = (m == LPM_RUN) || (m == LPM_RST_REQ); // [RULE5]
    s_next.free_running_core_clock = s_next.cpu_clk || ((m == LPM_SLEEP) && s_reg.dbg[0]) || ((m == LPM_STOP) && s_reg.dbg[1]) ||
                  (((m == LPM_STANDBY) || (m == LPM_STBY_WAKE)) && s_reg.dbg[2]); // [RULE19]
    s_next.bus_clk = s_next.free_running_core_clock || (m == LPM_SLEEP) || (m == LPM_STOP_WAKE); // [RULE19]
    // Stop wake ramps the internal fast oscillator only
    s_next.hs_clk = (m == LPM_RUN) || (m == LPM_SLEEP) || (m == LPM_STOP_WAKE) || (m == LPM_RST_REQ); // [RULE7]
    s_next.io_hiz = (m == LPM_STANDBY) || (m == LPM_STBY_WAKE); // [RULE13]
    s_next.ulp_bor = s_next.io_hiz; // [RULE13]
    s_next.core_retain = !s_next.io_hiz; // [RULE7] [RULE12]
    s_next.bkp_wr = s_next.bkp_unlock; // [RULE3]
    s_next.erase = |i_tamper; // [RULE16]
    s_next.on_bat = !i_main_supply_ok; // [RULE17]
    s_next.rst_req = (m == LPM_RST_REQ); // [RULE15] [RULE18]
    case (m)
      LPM_RUN, LPM_RST_REQ: s_next.pclk = '1;
      // Next mask, so a mask written during sleep gates at once
      LPM_SLEEP: s_next.pclk = s_next.pclk_sleep; // [RULE5]
      default: s_next.pclk = '0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s_reg <= '0;
      s_reg.scale <= `LPM_SCALE_RST;
      s_reg.pclk_sleep <= `LPM_PCLK_RST;
      s_reg.main_reg <= 1'b1;
      s_reg.cpu_clk <= 1'b1;
      s_reg.free_running_core_clock <= 1'b1;
      s_reg.bus_clk <= 1'b1;
      s_reg.hs_clk <= 1'b1;
      s_reg.core_retain <= 1'b1;
      s_reg.pclk <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rdata = s_reg.rdata;
  assign o_mode = s_reg.mode;
  assign o_main_reg_on = s_reg.main_reg;
  assign o_lp_reg_on = s_reg.lp_reg;
  assign o_under_drive = s_reg.udrv_on;
  assign o_cpu_clk_en = s_reg.cpu_clk;
  assign o_bus_clk_en = s_reg.bus_clk;
  assign o_free_running_core_clock_en = s_reg.free_running_core_clock;
  assign o_hs_clk_en = s_reg.hs_clk;
  assign o_sysclk_internal_fast_oscillator = s_reg.hsi_flag;
  assign o_io_hiz = s_reg.io_hiz;
  assign o_ulp_bor_on = s_reg.ulp_bor;
  assign o_core_retain = s_reg.core_retain;
  assign o_backup_wr_en = s_reg.bkp_wr;
  assign o_backup_erase = s_reg.erase;
  assign o_backup_on_battery = s_reg.on_bat;
  assign o_sys_reset_req = s_reg.rst_req;
  assign o_periph_clk_en = s_reg.pclk;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  localparam logic [`LPM_CNT_W-1:0] RAMP_MIN = `LPM_CNT_W'(`LPM_STOP_WAKE_MIN_CYC);
  localparam logic [`LPM_CNT_W-1:0] RAMP_MAX = `LPM_CNT_W'(`LPM_STOP_WAKE_MAX_CYC);

  // Ramp too long for a delay range; count it here, saturating to avoid wrap
  logic [`LPM_CNT_W-1:0] ramp_cyc;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || (o_mode != LPM_STOP_WAKE)) begin
      ramp_cyc <= '0;
    end else if (ramp_cyc != '1) begin
      ramp_cyc <= ramp_cyc + `LPM_CNT_W'(1);
    end
  end

  sequence s_stop_left;
    (o_mode == LPM_STOP) ##1 (o_mode == LPM_STOP_WAKE);
  endsequence
  sequence s_wake_ramp;
    (o_mode == LPM_STOP_WAKE) ##1 (o_mode == LPM_RUN);
  endsequence

  a_core_main_reg: assert property ((o_mode == LPM_RUN || o_mode == LPM_SLEEP) |-> o_main_reg_on && !o_lp_reg_on) // [RULE1]
    else $error("main regulator off in run or sleep");
  a_standby_regs_off: assert property ((o_mode == LPM_STANDBY && !s_reg.dbg[2]) |-> !o_main_reg_on && !o_lp_reg_on) // [RULE2]
    else $error("regulator on in standby");
  a_backup_lock: assert property ($past(i_sys_rst) |-> !o_backup_wr_en) // [RULE3]
    else $error("backup writable after reset");
  a_sleep_cpu_halt: assert property ((o_mode == LPM_SLEEP) |-> !o_cpu_clk_en && o_periph_clk_en == s_reg.pclk_sleep) // [RULE5]
    else $error("cpu clock running in sleep");
  a_wait_enters_sleep: assert property ((o_mode == LPM_RUN && !s_reg.rts && !s_reg.deep && i_wfi) |=> o_mode == LPM_SLEEP) // [RULE6]
    else $error("wait instruction did not sleep");
  a_stop_clocks_off: assert property ((o_mode == LPM_STOP) |-> !o_hs_clk_en && !o_cpu_clk_en && o_core_retain) // [RULE7]
    else $error("fast clock running in stop");
  a_stop_event_wake: assert property ((o_mode == LPM_STOP && i_external_event_lines) |=> o_mode == LPM_STOP_WAKE) // [RULE8]
    else $error("event line did not leave stop");
  a_stop_wake_time: assert property (s_wake_ramp |-> (ramp_cyc >= RAMP_MIN) && (ramp_cyc <= RAMP_MAX)) // [RULE9]
    else $error("stop wake time out of range");
  a_stop_wake_bound: assert property ((o_mode == LPM_STOP_WAKE) |-> (ramp_cyc < RAMP_MAX)) // [RULE9]
    else $error("stop wake ramp too long");
  a_ramp_fast_osc: assert property (s_stop_left |-> o_hs_clk_en && o_main_reg_on) // [RULE10]
    else $error("wake ramp without fast oscillator");
  a_wake_fast_osc: assert property ((o_mode == LPM_RUN && $past(o_mode) == LPM_STOP_WAKE) |-> o_sysclk_internal_fast_oscillator) // [RULE10]
    else $error("wake clock not internal fast oscillator");
  a_standby_io_hiz: assert property ((o_mode == LPM_STANDBY) |-> o_io_hiz && o_ulp_bor_on && !o_core_retain) // [RULE12]
    else $error("standby pins or brown-out wrong");
  a_pin_wakes_stby: assert property ((o_mode == LPM_STANDBY && stby_wake) |=> o_mode == LPM_STBY_WAKE) // [RULE14]
    else $error("wake pin ignored");
  a_tamper_erase: assert property ((|i_tamper) |=> o_backup_erase && s_reg.tamper_flag) // [RULE16]
    else $error("tamper did not erase");
  a_battery_switch: assert property (!i_main_supply_ok |=> o_backup_on_battery) // [RULE17]
    else $error("no battery switchover");
  a_opt_forbids_stop: assert property ((o_mode == LPM_RUN && sleep_req && s_reg.deep && !s_reg.stby_sel &&
                                        !i_opt_stop_allow) |=> o_sys_reset_req) // [RULE18]
    else $error("forbidden stop without reset");
endmodule
`default_nettype wire

// file: bench/lpm_cpu_model.sv
// Behavioural CPU core and wakeup sources that drive the power-mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defs.svh"
module lpm_cpu_model (
  input wire logic i_sys_clk,
  output logic o_wfi,
  output logic o_wfe,
  output logic o_isr_exit,
  output logic o_irq,
  output logic o_evt,
  output logic [`LPM_NWAKE-1:0] o_wake_pin
);
  initial begin
    o_wfi = 1'b0;
    o_wfe = 1'b0;
    o_isr_exit = 1'b0;
    o_irq = 1'b0;
    o_evt = 1'b0;
    o_wake_pin = 6'h3F;
  end
  // Instruction retire or handler exit is a single-cycle pulse
  task automatic instr(input int k);
    @(posedge i_sys_clk);
    case (k)
      0: o_wfi <= 1'b1;
      1: o_wfe <= 1'b1;
      default: o_isr_exit <= 1'b1;
    endcase
    @(posedge i_sys_clk);
    o_wfi <= 1'b0;
    o_wfe <= 1'b0;
    o_isr_exit <= 1'b0;
    #1;
  endtask
  // Wake sources are levels; one edge lets the controller react
  task automatic wake(input logic irq, input logic evt, input logic [`LPM_NWAKE-1:0] pins);
    @(posedge i_sys_clk);
    o_irq <= irq;
    o_evt <= evt;
    o_wake_pin <= pins;
    @(posedge i_sys_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_low_power_mode_controller.sv
// Self-checking bench of the power-mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defs.svh"
module tb_low_power_mode_controller;
  import lpm_pkg::*;
  // Short standby wake count keeps the run brief
  localparam int STBY_CYC = 20;
  localparam logic [7:0] RA [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h20};
  localparam logic [31:0] RV [6] = '{32'h10, 32'h0, 32'h0, 32'h0, 32'hFF, 32'h0};
  localparam logic [31:0] CV [5] = '{32'h10, 32'h50, 32'h20, 32'h60, 32'h30};
  localparam logic [31:0] LV [5] = '{32'hB4, 32'hD8, 32'hA8, 32'hB4, 32'h90};
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [`LPM_ADDR_W-1:0] i_addr;
  logic [`LPM_DATA_W-1:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [`LPM_NTAMPER-1:0] i_tamper;
  logic i_main_supply_ok;
  logic i_opt_stop_allow;
  logic i_opt_stby_allow;
  logic wfi, wfe, isr_exit, irq, evt;
  logic [`LPM_NWAKE-1:0] pins;
  logic [`LPM_DATA_W-1:0] rdata;
  lpm_mode_t mode;
  logic main_reg, lp_reg, udrv, cpu_clk, bus_clk, free_running_core_clock, hs_clk, fast_osc;
  logic io_hiz, ulp_bor, retain, bkp_wr, erase, on_bat, rst_req;
  logic [`LPM_NPCLK-1:0] pclk;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  lpm_cpu_model cpu (.i_sys_clk(i_sys_clk), .o_wfi(wfi), .o_wfe(wfe), .o_isr_exit(isr_exit),
    .o_irq(irq), .o_evt(evt), .o_wake_pin(pins));

  lpm_ctrl #(.STBY_WAKE_CYCLES(STBY_CYC)) dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_wfi(wfi), .i_wfe(wfe),
    .i_isr_exit_lowest(isr_exit), .i_irq_pending(irq), .i_external_event_lines(evt),
    .i_wake_pin(pins), .i_tamper(i_tamper), .i_main_supply_ok(i_main_supply_ok),
    .i_opt_stop_allow(i_opt_stop_allow), .i_opt_stby_allow(i_opt_stby_allow), .o_rdata(rdata),
    .o_mode(mode), .o_main_reg_on(main_reg), .o_lp_reg_on(lp_reg), .o_under_drive(udrv),
    .o_cpu_clk_en(cpu_clk), .o_bus_clk_en(bus_clk), .o_free_running_core_clock_en(free_running_core_clock),
    .o_hs_clk_en(hs_clk), .o_sysclk_internal_fast_oscillator(fast_osc), .o_io_hiz(io_hiz),
    .o_ulp_bor_on(ulp_bor), .o_core_retain(retain), .o_backup_wr_en(bkp_wr),
    .o_backup_erase(erase), .o_backup_on_battery(on_bat), .o_sys_reset_req(rst_req),
    .o_periph_clk_en(pclk));

  always #25 i_sys_clk = ~i_sys_clk;

  task automatic test_done();
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] snap();
    return 32'({1'b0, mode, main_reg, lp_reg, udrv, hs_clk, cpu_clk, retain, io_hiz, ulp_bor});
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk("read", rdata, e);
  endtask

  task automatic rst_dut();
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    #1;
  endtask

  task automatic wait_mode(input lpm_mode_t m, output int n);
    n = 0;
    while (mode === m && n < 5000) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
  endtask

  initial begin
    int n;
    i_addr <= '0;
    i_wdata <= '0;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    i_tamper <= '0;
    i_main_supply_ok <= 1'b1;
    i_opt_stop_allow <= 1'b1;
    i_opt_stby_allow <= 1'b1;
    rst_dut();
    chk("reset", snap(), 32'h09C);
    chk("lock", 32'({bkp_wr, pclk}), 32'h0FF);
    for (int i = 0; i < 6; i++) rc(RA[i], RV[i]);
    for (int i = 0; i < 5; i++) begin
      wr(`LPM_OFS_CTRL, CV[i]);
      rc(`LPM_OFS_CLKLIM, LV[i]);
    end
    // Limit table is read-only
    wr(`LPM_OFS_CLKLIM, 32'hFFFFFFFF);
    rc(`LPM_OFS_CLKLIM, 32'h90);
    wr(`LPM_OFS_CTRL, 32'h110);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("unlock", 32'(bkp_wr), 32'h1);
    wr(`LPM_OFS_PCLK, 32'hA5);
    wr(`LPM_OFS_CTRL, 32'h10);
    cpu.instr(0);
    chk("sleep", 32'({1'b0, mode, main_reg, cpu_clk, 2'h0, pclk}), 32'h18A5);
    cpu.wake(1'b1, 1'b0, 6'h3F);
    chk("sleepwake", 32'(mode), 32'h0);
    cpu.wake(1'b0, 1'b0, 6'h3F);
    wr(`LPM_OFS_CTRL, 32'h90);
    cpu.instr(1);
    chk("rts_instr", 32'(mode), 32'h0);
    cpu.instr(2);
    chk("rts_exit", 32'(mode), 32'h1);
    cpu.wake(1'b0, 1'b1, 6'h3F);
    cpu.wake(1'b0, 1'b0, 6'h3F);
    wr(`LPM_OFS_CTRL, 32'h11);
    cpu.instr(0);
    chk("stop", snap(), 32'h284);
    cpu.wake(1'b1, 1'b0, 6'h3F);
    chk("stop_irq", 32'(mode), 32'h2);
    cpu.wake(1'b0, 1'b1, 6'h3F);
    chk("stop_evt", 32'(mode), 32'h3);
    wait_mode(LPM_STOP_WAKE, n);
    chk("ramp_main", 32'(n), 32'h12C);
    chk("fast_osc", 32'({1'b0, mode, 3'h0, fast_osc}), 32'h01);
    cpu.wake(1'b0, 1'b0, 6'h3F);
    rc(`LPM_OFS_STATUS, 32'h40);
    wr(`LPM_OFS_STATUS, 32'h40);
    rc(`LPM_OFS_STATUS, 32'h0);
    wr(`LPM_OFS_CTRL, 32'h1D);
    cpu.instr(1);
    chk("stop_lp", snap(), 32'h264);
    cpu.wake(1'b0, 1'b1, 6'h3F);
    wait_mode(LPM_STOP_WAKE, n);
    chk("ramp_lp", 32'(n), 32'h960);
    cpu.wake(1'b0, 1'b0, 6'h3F);
    wr(`LPM_OFS_DEBUG, 32'h2);
    wr(`LPM_OFS_CTRL, 32'h11);
    cpu.instr(0);
    chk("dbg_stop", 32'({bus_clk, free_running_core_clock, hs_clk}), 32'h6);
    rst_dut();
    // Each forbidden deep mode must turn into a reset request
    for (int k = 0; k < 2; k++) begin
      @(posedge i_sys_clk);
      i_opt_stop_allow <= k[0];
      i_opt_stby_allow <= !k[0];
      wr(`LPM_OFS_CTRL, k[0] ? 32'h13 : 32'h11);
      cpu.instr(0);
      chk("opt_reset", 32'({1'b0, mode, 3'h0, rst_req}), 32'h61);
      @(posedge i_sys_clk);
      i_opt_stop_allow <= 1'b1;
      i_opt_stby_allow <= 1'b1;
      rst_dut();
    end
    wr(`LPM_OFS_WAKE, 32'h0404);
    wr(`LPM_OFS_CTRL, 32'h113);
    cpu.instr(0);
    chk("standby", snap(), 32'h403);
    cpu.wake(1'b1, 1'b1, 6'h3E);
    chk("stby_masked", 32'(mode), 32'h4);
    cpu.wake(1'b0, 1'b0, 6'h3B);
    chk("stby_pin", 32'(mode), 32'h5);
    wait_mode(LPM_STBY_WAKE, n);
    chk("stby_wait", 32'(n), 32'h14);
    chk("stby_reset", 32'({1'b0, mode, 3'h0, rst_req}), 32'h61);
    cpu.wake(1'b0, 1'b0, 6'h3F);
    rst_dut();
    chk("relock", 32'({bkp_wr, rst_req}), 32'h0);
    @(posedge i_sys_clk);
    i_tamper <= 2'h2;
    i_main_supply_ok <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk("tamper_bat", 32'({erase, on_bat}), 32'h3);
    rc(`LPM_OFS_STATUS, 32'h30);
    @(posedge i_sys_clk);
    i_tamper <= 2'h0;
    i_main_supply_ok <= 1'b1;
    @(posedge i_sys_clk);
    #1;
    chk("restore", 32'({erase, on_bat}), 32'h0);
    wr(`LPM_OFS_STATUS, 32'h20);
    rc(`LPM_OFS_STATUS, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
